//--- rac_addr_map.sv
// Shared constants of the rectifier control block and the address map.
// Assumes identifier levels arrive as millivolt codes from a converter
// that runs on the same clock.
`timescale 1ns/1ps
package rac_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_PER_MS = CLK_HZ / 1000;
   localparam int DELAY_S = 10;
   localparam int RAMP_MS = 120;
   localparam int AUX_LEAD_MS = 450;
   localparam int HOLDUP_MS = 15;
   localparam int PGW_MS = 3;
   localparam int AUX_HOLD_MS = 1000;
   localparam int BLINK_MS = 250;
   localparam int DELAY_CYC = DELAY_S * CLK_HZ;
   localparam int AUX_LEAD_CYC = AUX_LEAD_MS * CLK_PER_MS;
   localparam int PGW_LEAD_CYC = (HOLDUP_MS - PGW_MS) * CLK_PER_MS;
   localparam int AUX_HOLD_CYC = AUX_HOLD_MS * CLK_PER_MS;
   localparam int BLINK_CYC = BLINK_MS * CLK_PER_MS;
   localparam logic [6:0] RAMP_LO_PCT = 7'h0A;
   localparam logic [6:0] RAMP_HI_PCT = 7'h5A;
   localparam int RAMP_STEP_CYC = (RAMP_MS * CLK_PER_MS) / 80;
   localparam logic [11:0] PROG_LIMIT_MV = 12'hBB8;
   localparam logic [15:0] VOUT_DEFAULT_MV = 16'hD2F0;
   localparam logic [15:0] VOUT_PROG_MIN_MV = 16'hABE0;
   localparam logic [15:0] PROG_GAIN = 16'h000E;
   localparam logic [15:0] PROG_DIV = 16'h0003;
   localparam logic [15:0] PG_VOUT_MV = 16'h9C40;
   localparam logic [8:0] AC_BLINK_V = 9'h050;
   localparam logic [7:0] CMD_VOUT = 8'h21;
   localparam logic [2:0] ADDR_HI = 3'h4;
   localparam logic [6:0] ADDR_BCAST = 7'h00;
   localparam logic [1:0] SETTLE_CYC = 2'h3;
   localparam logic [3:0] UNIT_INVALID = 4'h0;
   localparam logic [11:0] UNIT_TH [10] = '{12'hC4E, 12'hB13, 12'h9C9,
      12'h87F, 12'h735, 12'h5EB, 12'h4A1, 12'h357, 12'h20D, 12'h0B4};
   localparam logic [11:0] RACK_TH [7] = '{12'hBEA, 12'h9F6, 12'h802,
      12'h640, 12'h4B0, 12'h2EE, 12'h0FA};
   localparam logic [3:0] ADDR_LUT [80] = '{
      4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0,
      4'h4, 4'h5, 4'h6, 4'h7, 4'h0, 4'h2, 4'h3, 4'h0, 4'h0, 4'h0,
      4'h8, 4'h9, 4'hA, 4'hB, 4'h0, 4'h4, 4'h5, 4'h0, 4'h0, 4'h0,
      4'hC, 4'hD, 4'hE, 4'hF, 4'h0, 4'h6, 4'h7, 4'h0, 4'h1, 4'h2,
      4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h9, 4'h3, 4'h4, 4'h5,
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hA, 4'hB, 4'h6, 4'h7, 4'h8,
      4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hC, 4'hD, 4'h9, 4'hA, 4'hB,
      4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hE, 4'hF, 4'hC, 4'hD, 4'hE};
   typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_RAMP, ST_ON} rac_st_t;
endpackage

module rac_addr_map
   import rac_pkg::*;
(
   input wire logic [11:0] unit_select_level_i,
   input wire logic [11:0] rack_select_level_i,
   output logic [3:0] unit_num_o,
   output logic [3:0] rack_num_o,
   output logic [3:0] addr_cfg_o
);
   logic [6:0] idx;

   // R4: unit level bands
   always_comb begin
      unit_num_o = 4'hA;
      for (int i = 9; i >= 0; i--) begin
         if (unit_select_level_i > UNIT_TH[i]) begin
            unit_num_o = 4'(i);
         end
      end
   end

   // R5: rack level bands
   always_comb begin
      rack_num_o = 4'h8;
      for (int i = 6; i >= 0; i--) begin
         if (rack_select_level_i > RACK_TH[i]) begin
            rack_num_o = 4'(i + 1);
         end
      end
   end

   // R16: fixed address lookup
   always_comb begin
      idx = 7'(({3'h0, rack_num_o} - 7'h01) * 7'h0A)
         + 7'({3'h0, unit_num_o} - 7'h01);
      if (unit_num_o == UNIT_INVALID) begin
         addr_cfg_o = 4'h0;
      end else begin
         addr_cfg_o = ADDR_LUT[idx];
      end
   end
endmodule

//--- rac_ctrl.sv
// Rectifier management control: address and mode straps, setpoint
// ownership, output start sequencing, warning and input indicator.
// Assumes levels are millivolt codes on clock_i; straps are async pins.
// Contract
// R1: target address is 100 then the four configured bits, 40 to 4F.
// R2: address byte bit 0 is direction, 0 write, 1 read.
// R3: address bits come only from sampled unit and rack levels.
// R4: unit level decodes into eleven bands, invalid and units 1 to 10.
// R5: rack level decodes into eight values, 3.3 V is the default.
// R6: open mode pin selects I2C, resistor to return selects RS485.
// R7: under hardware, pin below 3 V sets output, else default 54 V.
// R8: after command 0x21 executes, the programming pin is ignored.
// R9: in I2C mode wait 10 s after input returns before output rises.
// R10: in I2C mode output ramps 10 to 90 percent over 120 ms.
// R11: power good warning rises 3 ms before output falls below 40 V.
// R12: aux standby is on at least 450 ms before main reaches regulation.
// R13: input indicator blinks while input is below 80 V AC.
// R14: firmware ownership lasts until controller reset.
// R15: a read through the broadcast address reports invalid command.
// R16: fixed lookup maps unit and rack to address bits, else 0000.
// R17: broadcast writes act exactly as writes to own address.
// R18: straps are sampled once after reset and held until next reset.
`timescale 1ns/1ps
module rac_ctrl
   import rac_pkg::*;
#(
   parameter int DELAY_CYCLES = DELAY_CYC,
   parameter int AUX_LEAD_CYCLES = AUX_LEAD_CYC,
   parameter int RAMP_STEP_CYCLES = RAMP_STEP_CYC,
   parameter int PGW_LEAD_CYCLES = PGW_LEAD_CYC,
   parameter int AUX_HOLD_CYCLES = AUX_HOLD_CYC,
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [11:0] unit_select_level_i,
   input wire logic [11:0] rack_select_level_i,
   input wire logic mode_pin_open_i,
   input wire logic [11:0] prog_level_i,
   input wire logic ac_in_ok_i,
   input wire logic [8:0] ac_in_volts_i,
   input wire logic [15:0] vout_mv_i,
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_addr_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [15:0] cmd_data_i,
   output logic [6:0] target_addr_o,
   output logic i2c_mode_o,
   output logic cfg_valid_o,
   output logic cmd_ack_o,
   output logic invalid_cmd_o,
   output logic fw_owner_o,
   output logic [15:0] setpoint_mv_o,
   output logic main_enable_o,
   output logic [6:0] ramp_pct_o,
   output logic main_in_reg_o,
   output logic aux_standby_output_o,
   output logic power_good_warning_o,
   output logic input_led_o
);
   logic [3:0] addr_cfg;
   logic [2:0] mode_s_q, mode_s_d, ac_s_q, ac_s_d;
   logic mode_f_q, mode_f_d, ac_f_q, ac_f_d;
   logic [1:0] settle_q, settle_d;
   logic cfg_q, cfg_d, i2c_q, i2c_d;
   logic [3:0] addr_q, addr_d;
   logic own, bcast, ack_q, ack_d, inv_q, inv_d;
   logic fw_q, fw_d;
   logic [15:0] fw_mv_q, fw_mv_d, sp_q, sp_d;
   rac_st_t st_q, st_d;
   logic [31:0] cnt_q, cnt_d, loss_q, loss_d, blink_q, blink_d;
   logic [6:0] pct_q, pct_d;
   logic aux_q, aux_d, pgw_q, pgw_d, led_q, led_d;

   function automatic logic [31:0] sat_inc(input logic [31:0] v);
      sat_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h00000001;
   endfunction

   rac_addr_map u_map (
      .unit_select_level_i(unit_select_level_i),
      .rack_select_level_i(rack_select_level_i),
      .unit_num_o(),
      .rack_num_o(),
      .addr_cfg_o(addr_cfg)
   );

   // Mode strap and input-good pass three flops; accept once two agree
   always_comb begin
      mode_s_d = {mode_s_q[1:0], mode_pin_open_i};
      ac_s_d = {ac_s_q[1:0], ac_in_ok_i};
      mode_f_d = (mode_s_q[2] == mode_s_q[1]) ? mode_s_q[2] : mode_f_q;
      ac_f_d = (ac_s_q[2] == ac_s_q[1]) ? ac_s_q[2] : ac_f_q;
      settle_d = settle_q;
      cfg_d = cfg_q;
      i2c_d = i2c_q;
      addr_d = addr_q;
      // R18: one sample after settling
      if (!cfg_q) begin
         if (settle_q == SETTLE_CYC) begin
            cfg_d = 1'b1;
            // R6: open pin means I2C
            i2c_d = mode_f_q;
            // R3: address from identifier levels
            addr_d = addr_cfg;
         end else begin
            settle_d = settle_q + 2'h1;
         end
      end
   end

   // R1: fixed high bits, R2: bit 0 is direction
   assign own = cfg_q && (cmd_addr_i[7:1] == {ADDR_HI, addr_q});
   assign bcast = cfg_q && (cmd_addr_i[7:1] == ADDR_BCAST);

   always_comb begin
      ack_d = 1'b0;
      inv_d = 1'b0;
      fw_d = fw_q;
      fw_mv_d = fw_mv_q;
      if (cmd_valid_i) begin
         // R15: broadcast read refused
         if (bcast && cmd_addr_i[0]) begin
            inv_d = 1'b1;
         // R17: broadcast write treated as own
         end else if ((own || bcast) && !cmd_addr_i[0]) begin
            ack_d = 1'b1;
            // R8: firmware takes the setpoint
            if (cmd_code_i == CMD_VOUT) begin
               fw_d = 1'b1;
               fw_mv_d = cmd_data_i;
            end
         end else if (own) begin
            ack_d = 1'b1;
         end
      end
      // R7: pin below limit sets output
      if (fw_q) begin
         sp_d = fw_mv_q;
      end else if (prog_level_i < PROG_LIMIT_MV) begin
         sp_d = VOUT_PROG_MIN_MV
            + ({4'h0, prog_level_i} * PROG_GAIN) / PROG_DIV;
      end else begin
         sp_d = VOUT_DEFAULT_MV;
      end
   end

   // Start sequencing; RS485 has no long delay but keeps the aux lead
   always_comb begin
      st_d = st_q;
      cnt_d = sat_inc(cnt_q);
      pct_d = pct_q;
      loss_d = ac_f_q ? 32'h0 : sat_inc(loss_q);
      aux_d = aux_q;
      if (ac_f_q) begin
         aux_d = 1'b1;
      end else if (loss_q >= 32'(AUX_HOLD_CYCLES)) begin
         aux_d = 1'b0;
      end
      case (st_q)
         ST_OFF: begin
            if (ac_f_q && cfg_q) begin
               st_d = ST_WAIT;
               cnt_d = 32'h0;
            end
         end
         ST_WAIT: begin
            // R9: ten second delay; R12: aux lead
            if (!ac_f_q) begin
               st_d = ST_OFF;
            end else if (cnt_q >= 32'(i2c_q ? DELAY_CYCLES
                  : AUX_LEAD_CYCLES)) begin
               st_d = ST_RAMP;
               cnt_d = 32'h0;
               pct_d = RAMP_LO_PCT;
            end
         end
         ST_RAMP: begin
            // R10: 80 steps over the rise interval
            if (!ac_f_q) begin
               st_d = ST_OFF;
            end else if (cnt_q >= 32'(RAMP_STEP_CYCLES - 1)) begin
               cnt_d = 32'h0;
               pct_d = pct_q + 7'h01;
               if (pct_q + 7'h01 == RAMP_HI_PCT) begin
                  st_d = ST_ON;
               end
            end
         end
         ST_ON: begin
            if (!ac_f_q) begin
               st_d = ST_OFF;
            end
         end
         default: st_d = ST_OFF;
      endcase
      if (st_d == ST_OFF) begin
         pct_d = 7'h0;
      end
      // R11: warn ahead of hold-up end or on low output
      pgw_d = (loss_q >= 32'(PGW_LEAD_CYCLES))
         || (st_q == ST_ON && vout_mv_i < PG_VOUT_MV);
      // R13: blink on low input
      blink_d = sat_inc(blink_q);
      led_d = led_q;
      if (ac_in_volts_i >= AC_BLINK_V) begin
         led_d = 1'b1;
         blink_d = 32'h0;
      end else if (blink_q >= 32'(BLINK_CYCLES - 1)) begin
         led_d = !led_q;
         blink_d = 32'h0;
      end
   end

   always_ff @(posedge clock_i) begin
      mode_s_q <= mode_s_d;
      ac_s_q <= ac_s_d;
      if (rst_i) begin
         // R14: reset drops firmware ownership
         mode_f_q <= 1'b1;
         ac_f_q <= 1'b0;
         settle_q <= 2'h0;
         cfg_q <= 1'b0;
         i2c_q <= 1'b1;
         addr_q <= 4'h0;
         ack_q <= 1'b0;
         inv_q <= 1'b0;
         fw_q <= 1'b0;
         fw_mv_q <= VOUT_DEFAULT_MV;
         sp_q <= VOUT_DEFAULT_MV;
         st_q <= ST_OFF;
         cnt_q <= 32'h0;
         pct_q <= 7'h0;
         loss_q <= 32'h0;
         aux_q <= 1'b0;
         pgw_q <= 1'b0;
         blink_q <= 32'h0;
         led_q <= 1'b1;
      end else begin
         mode_f_q <= mode_f_d;
         ac_f_q <= ac_f_d;
         settle_q <= settle_d;
         cfg_q <= cfg_d;
         i2c_q <= i2c_d;
         addr_q <= addr_d;
         ack_q <= ack_d;
         inv_q <= inv_d;
         fw_q <= fw_d;
         fw_mv_q <= fw_mv_d;
         sp_q <= sp_d;
         st_q <= st_d;
         cnt_q <= cnt_d;
         pct_q <= pct_d;
         loss_q <= loss_d;
         aux_q <= aux_d;
         pgw_q <= pgw_d;
         blink_q <= blink_d;
         led_q <= led_d;
      end
   end

   assign target_addr_o = {ADDR_HI, addr_q};
   assign i2c_mode_o = i2c_q;
   assign cfg_valid_o = cfg_q;
   assign cmd_ack_o = ack_q;
   assign invalid_cmd_o = inv_q;
   assign fw_owner_o = fw_q;
   assign setpoint_mv_o = sp_q;
   assign main_enable_o = (st_q == ST_RAMP) || (st_q == ST_ON);
   assign ramp_pct_o = pct_q;
   assign main_in_reg_o = (st_q == ST_ON);
   assign aux_standby_output_o = aux_q;
   assign power_good_warning_o = pgw_q;
   assign input_led_o = led_q;

   sequence bcast_read_s;
      cmd_valid_i && cmd_addr_i[7:1] == ADDR_BCAST && cmd_addr_i[0]
         && cfg_q;
   endsequence
   sequence fw_write_s;
      cmd_valid_i && !cmd_addr_i[0] && cmd_code_i == CMD_VOUT
         && cfg_q && (cmd_addr_i[7:1] == ADDR_BCAST
         || cmd_addr_i[7:1] == {ADDR_HI, addr_q});
   endsequence

   addr_prefix_a: assert property (@(posedge clock_i) disable iff (rst_i) // R1
      target_addr_o[6:4] == 3'h4)
      else $error("target address prefix wrong");
   bcast_read_a: assert property (@(posedge clock_i) disable iff (rst_i) // R15
      bcast_read_s |=> invalid_cmd_o && !cmd_ack_o)
      else $error("broadcast read not flagged");
   bcast_write_a: assert property (@(posedge clock_i) disable iff (rst_i) // R17
      fw_write_s |=> cmd_ack_o && fw_owner_o
         && fw_mv_q == $past(cmd_data_i))
      else $error("setpoint write not taken");
   pin_ignored_a: assert property (@(posedge clock_i) disable iff (rst_i) // R8
      fw_owner_o |=> ##1 setpoint_mv_o == $past(fw_mv_q))
      else $error("setpoint not from firmware");
   pin_default_a: assert property (@(posedge clock_i) disable iff (rst_i) // R7
      !fw_q && !fw_d && prog_level_i >= 12'hBB8
         |=> setpoint_mv_o == 16'hD2F0)
      else $error("default setpoint missing");
   reset_owner_a: assert property (@(posedge clock_i) // R14
      rst_i |=> !fw_owner_o && setpoint_mv_o == 16'hD2F0)
      else $error("ownership survived reset");
   strap_hold_a: assert property (@(posedge clock_i) disable iff (rst_i) // R18
      cfg_q |=> cfg_q && $stable(target_addr_o) && $stable(i2c_mode_o))
      else $error("strap value changed");
   start_delay_a: assert property (@(posedge clock_i) disable iff (rst_i) // R9
      st_q == ST_WAIT && st_d == ST_RAMP && i2c_q
         |-> cnt_q >= 32'(DELAY_CYCLES))
      else $error("main output started early");
   ramp_start_a: assert property (@(posedge clock_i) disable iff (rst_i) // R10
      $rose(st_q == ST_RAMP) |-> ramp_pct_o == 7'h0A
         ##1 (ramp_pct_o == 7'h0A || !main_enable_o))
      else $error("ramp does not start at ten percent");
   aux_lead_a: assert property (@(posedge clock_i) disable iff (rst_i) // R12
      $rose(main_in_reg_o) |-> aux_standby_output_o)
      else $error("main regulated without aux");
   warn_lead_a: assert property (@(posedge clock_i) disable iff (rst_i) // R11
      loss_q >= 32'(PGW_LEAD_CYCLES) |=> power_good_warning_o)
      else $error("power good warning late");
   led_steady_a: assert property (@(posedge clock_i) disable iff (rst_i) // R13
      ac_in_volts_i >= 9'h050 |=> input_led_o)
      else $error("indicator blinks on good input");
endmodule

//--- rac_host_model.sv
// Host controller model: issues decoded bus transactions to the block.
// Assumes its tasks are called at the falling clock edge.
`timescale 1ns/1ps
module rac_host_model (
   input wire logic clock_i,
   input wire logic cmd_ack_i,
   input wire logic invalid_cmd_i,
   output logic cmd_valid_o,
   output logic [7:0] cmd_addr_o,
   output logic [7:0] cmd_code_o,
   output logic [15:0] cmd_data_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_addr_o = 8'h00;
      cmd_code_o = 8'h00;
      cmd_data_o = 16'h0000;
   end

   // byte is 100, bits, then direction
   function automatic logic [7:0] own_byte(input logic [3:0] bits,
                                           input logic rd);
      return {3'h4, bits, rd};
   endfunction

   // One-cycle request; answer is taken at the falling edge after the request edge
   task automatic send(input logic [7:0] addr, input logic [7:0] code,
                       input logic [15:0] data, output logic ack,
                       output logic inv);
      cmd_valid_o = 1'b1;
      cmd_addr_o = addr;
      cmd_code_o = code;
      cmd_data_o = data;
      @(posedge clock_i);
      @(negedge clock_i);
      ack = cmd_ack_i;
      inv = invalid_cmd_i;
   endtask

   // Released fields flip so stale values never look valid
   task automatic idle();
      cmd_valid_o = 1'b0;
      cmd_addr_o = ~cmd_addr_o;
      cmd_code_o = ~cmd_code_o;
      cmd_data_o = ~cmd_data_o;
      @(negedge clock_i);
   endtask
endmodule

//--- rac_ctrl_tb.sv
// Self-checking bench for the rectifier control block.
// Assumes shortened timing parameters; host model drives commands.
`timescale 1ns/1ps
module rac_ctrl_tb;
   logic clock_i = 1'b0, rst_i = 1'b1, mode_open, ac_ok;
   logic [11:0] unit_lvl, rack_lvl, prog;
   logic [8:0] ac_volts;
   logic [15:0] vout;
   logic cmd_valid, cmd_ack_o, invalid_cmd_o, i2c_mode_o, cfg_valid_o;
   logic [7:0] cmd_addr, cmd_code;
   logic [15:0] cmd_data, setpoint_mv_o;
   logic [6:0] target_addr_o, ramp_pct_o;
   logic fw_owner_o, main_enable_o, main_in_reg_o, aux_standby_output_o;
   logic power_good_warning_o, input_led_o;
   int error_cnt = 0;
   int n_checks = 0;
   localparam logic [11:0] U_TAB [7] = '{12'hBB8, 12'h7DA, 12'hA6E,
      12'hCE4, 12'h000, 12'h546, 12'h3FC};
   localparam logic [11:0] R_TAB [7] = '{12'hCE4, 12'h708, 12'hAF0,
      12'h8FC, 12'h000, 12'h578, 12'h8FC};
   localparam logic [3:0] B_TAB [7] = '{4'h0, 4'hF, 4'h5, 4'h0, 4'hE,
      4'h8, 4'h5};
   localparam logic [11:0] P_TAB [4] = '{12'h5DC, 12'hBB7, 12'hBB8,
      12'hCE4};

   always #10 clock_i = ~clock_i;

   rac_ctrl #(.DELAY_CYCLES(40), .AUX_LEAD_CYCLES(20), .RAMP_STEP_CYCLES(2),
      .PGW_LEAD_CYCLES(10), .AUX_HOLD_CYCLES(30), .BLINK_CYCLES(4)) i_rac_ctrl (
      .clock_i(clock_i), .rst_i(rst_i), .unit_select_level_i(unit_lvl),
      .rack_select_level_i(rack_lvl), .mode_pin_open_i(mode_open),
      .prog_level_i(prog), .ac_in_ok_i(ac_ok), .ac_in_volts_i(ac_volts),
      .vout_mv_i(vout), .cmd_valid_i(cmd_valid), .cmd_addr_i(cmd_addr),
      .cmd_code_i(cmd_code), .cmd_data_i(cmd_data),
      .target_addr_o(target_addr_o), .i2c_mode_o(i2c_mode_o),
      .cfg_valid_o(cfg_valid_o), .cmd_ack_o(cmd_ack_o),
      .invalid_cmd_o(invalid_cmd_o), .fw_owner_o(fw_owner_o),
      .setpoint_mv_o(setpoint_mv_o), .main_enable_o(main_enable_o),
      .ramp_pct_o(ramp_pct_o), .main_in_reg_o(main_in_reg_o),
      .aux_standby_output_o(aux_standby_output_o),
      .power_good_warning_o(power_good_warning_o),
      .input_led_o(input_led_o));

   rac_host_model i_rac_host_model (.clock_i(clock_i), .cmd_ack_i(cmd_ack_o),
      .invalid_cmd_i(invalid_cmd_o), .cmd_valid_o(cmd_valid),
      .cmd_addr_o(cmd_addr), .cmd_code_o(cmd_code), .cmd_data_o(cmd_data));

   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string w);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %b expected %b", $time, w, got, exp);
      end
   endtask

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
                           input string w);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, w, got, exp);
      end
   endtask

   task automatic chk_range(input int n, input int lo, input int hi,
                            input string w);
      n_checks++;
      if (n < lo || n > hi) begin
         error_cnt++;
         $display("Error at %0t: %s took %0d cycles", $time, w, n);
      end
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return main_enable_o;
         1: return main_in_reg_o;
         2: return power_good_warning_o;
         3: return cfg_valid_o;
         default: return aux_standby_output_o;
      endcase
   endfunction

   // Bounded wait; running out ends the run as a failure
   task automatic wait_for(input int sel, input logic lvl, input int lim,
                           output int n);
      n = 0;
      while (pick(sel) !== lvl && n < lim) begin
         @(negedge clock_i);
         n++;
      end
      if (n >= lim) begin
         error_cnt++;
         $display("Error at %0t: wait %0d timed out", $time, sel);
         tally_and_finish();
      end
   endtask

   function automatic logic [15:0] hw_set(input logic [11:0] p);
      return (p < 12'hBB8) ? 16'(44000 + int'(p) * 14 / 3) : 16'hD2F0;
   endfunction

   task automatic do_reset(input logic [11:0] u, input logic [11:0] r,
                           input logic m);
      int n;
      logic a, v;
      unit_lvl = u;
      rack_lvl = r;
      mode_open = m;
      rst_i = 1'b1;
      repeat (5) @(negedge clock_i);
      chk_word({9'h000, target_addr_o}, 16'h0040, "reset address");
      chk_word(setpoint_mv_o, 16'hD2F0, "reset setpoint");
      chk_bit(cfg_valid_o | fw_owner_o | aux_standby_output_o, 1'b0, "flags");
      chk_bit(input_led_o & i2c_mode_o, 1'b1, "reset led and mode");
      rst_i = 1'b0;
      i_rac_host_model.send(8'h81, 8'h00, 16'h0000, a, v);
      chk_bit(a, 1'b0, "command before sampling");
      i_rac_host_model.idle();
      wait_for(3, 1'b1, 20, n);
   endtask

   initial begin
      int n, t;
      logic a, v;
      // Pin levels start idle: open straps, input absent, good output
      mode_open = 1'b1;
      ac_ok = 1'b0;
      prog = 12'hCE4;
      ac_volts = 9'h064;
      vout = 16'hD2F0;
      do_reset(12'hBB8, 12'hCE4, 1'b1);
      for (int i = 0; i < 7; i++) begin
         do_reset(U_TAB[i], R_TAB[i], 1'b1);
         chk_word({9'h000, target_addr_o}, {9'h000, 3'h4, B_TAB[i]}, "addr");
         unit_lvl = 12'h000;
         rack_lvl = 12'h000;
         repeat (6) @(negedge clock_i);
         chk_word({9'h000, target_addr_o}, {9'h000, 3'h4, B_TAB[i]}, "held");
         i_rac_host_model.send({3'h4, B_TAB[i], 1'b1}, 8'h00, 16'h0, a, v);
         chk_bit(a, 1'b1, "own read");
         i_rac_host_model.send({3'h4, ~B_TAB[i], 1'b0}, 8'h21, 16'h0, a, v);
         chk_bit(a | v, 1'b0, "foreign address");
         i_rac_host_model.idle();
      end
      do_reset(12'hBB8, 12'hCE4, 1'b0);
      chk_bit(i2c_mode_o, 1'b0, "serial mode");
      mode_open = 1'b1;
      ac_ok = 1'b1;
      wait_for(0, 1'b1, 60, n);
      chk_range(n, 21, 27, "serial start delay");
      chk_bit(i2c_mode_o, 1'b0, "mode held");
      ac_ok = 1'b0;
      do_reset(12'hBB8, 12'hCE4, 1'b1);
      chk_bit(i2c_mode_o, 1'b1, "bus mode");
      foreach (P_TAB[i]) begin
         prog = P_TAB[i];
         repeat (3) @(negedge clock_i);
         chk_word(setpoint_mv_o, hw_set(P_TAB[i]), "pin setpoint");
      end
      i_rac_host_model.send(8'h01, 8'h00, 16'h0000, a, v);
      chk_bit(v & ~a, 1'b1, "broadcast read");
      i_rac_host_model.send(8'h00, 8'h21, 16'hC350, a, v);
      chk_bit(a & ~v, 1'b1, "broadcast write");
      i_rac_host_model.idle();
      chk_bit(fw_owner_o, 1'b1, "firmware owner");
      prog = 12'h5DC;
      repeat (3) @(negedge clock_i);
      chk_word(setpoint_mv_o, 16'hC350, "pin ignored");
      i_rac_host_model.send(8'h80, 8'h21, 16'hBB80, a, v);
      i_rac_host_model.idle();
      chk_word(setpoint_mv_o, 16'hBB80, "own write setpoint");
      do_reset(12'hBB8, 12'hCE4, 1'b1);
      repeat (2) @(negedge clock_i);
      chk_word(setpoint_mv_o, hw_set(12'h5DC), "pin after reset");
      ac_ok = 1'b1;
      wait_for(0, 1'b1, 80, n);
      chk_range(n, 40, 47, "start delay");
      chk_word({9'h000, ramp_pct_o}, 16'h000A, "ramp start");
      chk_bit(aux_standby_output_o, 1'b1, "aux leads main");
      wait_for(1, 1'b1, 200, n);
      chk_range(n, 158, 162, "ramp length");
      chk_word({9'h000, ramp_pct_o}, 16'h005A, "ramp end");
      vout = 16'h9C40;
      repeat (3) @(negedge clock_i);
      chk_bit(power_good_warning_o, 1'b0, "at 40 V");
      vout = 16'h9858;
      wait_for(2, 1'b1, 4, n);
      vout = 16'hD2F0;
      wait_for(2, 1'b0, 4, n);
      ac_ok = 1'b0;
      wait_for(2, 1'b1, 25, n);
      chk_range(n, 10, 17, "loss warning");
      chk_bit(main_enable_o | ramp_pct_o[3], 1'b0, "main off on loss");
      chk_bit(aux_standby_output_o, 1'b1, "aux holds");
      wait_for(4, 1'b0, 40, n);
      chk_range(n, 10, 24, "aux hold");
      ac_volts = 9'h046;
      t = 0;
      repeat (16) begin
         a = input_led_o;
         @(negedge clock_i);
         if (input_led_o !== a) t++;
      end
      chk_range(t, 3, 5, "blink toggles");
      ac_volts = 9'h050;
      repeat (2) @(negedge clock_i);
      repeat (8) begin
         chk_bit(input_led_o, 1'b1, "steady led");
         @(negedge clock_i);
      end
      tally_and_finish();
   end
endmodule
